// File: hdl/tsr_regs.svh
// Offsets, field positions, reset values and load-divide codes of the sequencer register set.
// Included by the package and the register module; definitions only.
`ifndef TSR_REGS_SVH
`define TSR_REGS_SVH

`define TSR_PORT_INDEX       16'h03c4
`define TSR_PORT_DATA        16'h03c5
`define TSR_IDX_RESET_CTRL   3'h0
`define TSR_IDX_CLOCK_MODE   3'h1
`define TSR_IDX_PLANE_MASK   3'h2
`define TSR_IDX_FONT_SEL     3'h3
`define TSR_IDX_MEM_MODE     3'h4
`define TSR_IDX_RESERVED     3'h5
`define TSR_IDX_STATE_CTRL   3'h6
`define TSR_IDX_AUX_MODE     3'h7
`define TSR_INDEX_MASK       8'h07
`define TSR_RESET_CTRL_MASK  8'h03
`define TSR_CLOCK_MODE_MASK  8'h3d
`define TSR_PLANE_MASK_MASK  8'h0f
`define TSR_FONT_SEL_MASK    8'h3f
`define TSR_MEM_MODE_MASK    8'h0e
`define TSR_STATE_CTRL_MASK  8'h06
`define TSR_AUX_MODE_MASK    8'hfd
`define TSR_RST_ASYNC_BIT    0
`define TSR_RST_SYNC_BIT     1
`define TSR_MODE_STATE_BIT   0
`define TSR_MODE_LOAD2_BIT   2
`define TSR_MODE_DOT2_BIT    3
`define TSR_MODE_SHIFT4_BIT  4
`define TSR_MODE_SCROFF_BIT  5
`define TSR_FONT_A_B2        4
`define TSR_FONT_A_B1        1
`define TSR_FONT_A_B0        0
`define TSR_FONT_B_B2        5
`define TSR_FONT_B_B1        3
`define TSR_FONT_B_B0        2
`define TSR_RESET_VAL        8'h00
`define TSR_LOAD_DIV_FULL    2'h0
`define TSR_LOAD_DIV_HALF    2'h1
`define TSR_LOAD_DIV_QUARTER 2'h3

`endif

// File: hdl/tsr_pkg.sv
// Types of the sequencer register set.
// Assumes tsr_regs.svh is on the include path.
`include "tsr_regs.svh"
package tsr_pkg;
   typedef enum logic [1:0] {
      TSR_HALTED  = 2'b01,
      TSR_RUNNING = 2'b10
   } tsr_run_state_t;
   typedef logic [7:0]  tsr_byte_t;
   typedef logic [15:0] tsr_font_offset_t;
endpackage

// File: hdl/tsr_font_map.sv
// Maps a three-bit soft font choice to its byte offset in font memory.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
module tsr_font_map
   import tsr_pkg::*;
(
   input  wire logic [2:0]       i_choice,
   output var tsr_font_offset_t  o_offset
);
   // The low two bits pick a 16K segment and the top bit adds 8K.
   always_comb begin
      o_offset = {i_choice[1:0], i_choice[2], 13'h0000};
   end
endmodule // tsr_font_map
`default_nettype wire

// File: hdl/tsr_sequencer_regs.sv
// Indexed control registers of the timing sequencer, reached through the index
// and data I/O ports. Assumes a host I/O strobe bus synchronous to i_clock.
`timescale 1ns/1ps
`default_nettype none
`include "tsr_regs.svh"
module tsr_sequencer_regs
   import tsr_pkg::*;
(
   input  wire logic              i_clock,
   input  wire logic              i_reset_n,
   input  wire logic              i_clock_en,
   input  wire logic [15:0]       i_io_addr,
   input  wire logic              i_io_wr,
   input  wire logic              i_io_rd,
   input  wire logic [7:0]        i_io_wdata,
   input  wire logic              i_attr_font_b,
   input  wire logic              i_attribute_controller_font_override,
   input  wire logic [2:0]        i_alt_font_choice,
   output logic      [7:0]        o_io_rdata,
   output logic                   o_io_rd_hit,
   output logic                   o_seq_run,
   output logic                   o_screen_blank,
   output logic                   o_fast_cpu_access,
   output logic      [1:0]        o_load_divide,
   output logic                   o_dot_clock_half,
   output logic                   o_char_clock_8dot,
   output logic      [2:0]        o_dot_state_ext,
   output logic      [3:0]        o_plane_write_enable,
   output logic      [15:0]       o_font_offset,
   output logic      [7:0]        o_memory_mode,
   output logic      [7:0]        o_aux_mode
);
   tsr_byte_t        sequencer_index;
   tsr_byte_t        regs [8];
   tsr_run_state_t   run_state;
   tsr_byte_t        next_index;
   tsr_byte_t        next_regs [8];
   tsr_run_state_t   next_run_state;
   tsr_byte_t        next_rdata;
   logic             next_rd_hit;
   logic             index_hit;
   logic             data_hit;
   logic [2:0]       font_choice_a;
   logic [2:0]       font_choice_b;
   logic [2:0]       font_choice;
   tsr_font_offset_t font_offset;
   tsr_byte_t        wmask [8];
   logic             next_seq_run;
   logic             next_screen_blank;
   logic             next_fast_cpu_access;
   logic [1:0]       next_load_divide;
   logic             next_dot_clock_half;
   logic             next_char_clock_8dot;
   logic [2:0]       next_dot_state_ext;
   logic [3:0]       next_plane_write_enable;

   assign wmask[0] = `TSR_RESET_CTRL_MASK;
   assign wmask[1] = `TSR_CLOCK_MODE_MASK;
   assign wmask[2] = `TSR_PLANE_MASK_MASK;
   assign wmask[3] = `TSR_FONT_SEL_MASK;
   assign wmask[4] = `TSR_MEM_MODE_MASK;
   assign wmask[5] = `TSR_RESET_VAL;
   assign wmask[6] = `TSR_STATE_CTRL_MASK;
   assign wmask[7] = `TSR_AUX_MODE_MASK;

   // Address decoding of the two ports.
   always_comb begin
      index_hit = 1'b0;
      data_hit  = 1'b0;
      if (i_io_addr == `TSR_PORT_INDEX) begin
         index_hit = 1'b1;
      end else if (i_io_addr == `TSR_PORT_DATA) begin
         data_hit = 1'b1;
      end
   end

   // Register writes and read data.
   always_comb begin
      next_index  = sequencer_index;
      next_rdata  = `TSR_RESET_VAL;
      next_rd_hit = 1'b0;
      for (int k = 0; k < 8; k++) begin
         next_regs[k] = regs[k];
      end
      if (i_io_wr && index_hit) begin
         next_index = i_io_wdata & `TSR_INDEX_MASK;
      end else if (i_io_wr && data_hit) begin
         // Masking drops reserved bits, so index 5 never stores anything.
         next_regs[sequencer_index[2:0]] = i_io_wdata & wmask[sequencer_index[2:0]];
      end
      if (i_io_rd && index_hit) begin
         next_rdata  = sequencer_index;
         next_rd_hit = 1'b1;
      end else if (i_io_rd && data_hit) begin
         next_rdata  = regs[sequencer_index[2:0]];
         next_rd_hit = 1'b1;
      end
   end

   // Halting takes effect from the register value itself, so a write that clears
   // either bit stops the sequencer on the edge after the one that stores the write.
   always_comb begin
      case (run_state)
         TSR_HALTED: begin
            if (regs[0][`TSR_RST_ASYNC_BIT] && regs[0][`TSR_RST_SYNC_BIT]) begin
               next_run_state = TSR_RUNNING;
            end else begin
               next_run_state = TSR_HALTED;
            end
         end
         TSR_RUNNING: begin
            if (!(regs[0][`TSR_RST_ASYNC_BIT] && regs[0][`TSR_RST_SYNC_BIT])) begin
               next_run_state = TSR_HALTED;
            end else begin
               next_run_state = TSR_RUNNING;
            end
         end
         default: begin
            next_run_state = TSR_HALTED;
         end
      endcase
   end

   // Font choice: attribute bit 3 picks B, an override takes the outside choice.
   always_comb begin
      font_choice_a = {regs[3][`TSR_FONT_A_B2], regs[3][`TSR_FONT_A_B1],
                       regs[3][`TSR_FONT_A_B0]};
      font_choice_b = {regs[3][`TSR_FONT_B_B2], regs[3][`TSR_FONT_B_B1],
                       regs[3][`TSR_FONT_B_B0]};
      if (i_attribute_controller_font_override) begin
         font_choice = i_alt_font_choice;
      end else if (i_attr_font_b) begin
         font_choice = font_choice_b;
      end else begin
         font_choice = font_choice_a;
      end
   end

   // Derived controls follow the stored registers one edge later; the extra cycle keeps
   // every output a plain flip-flop with no decode logic behind the pin.
   always_comb begin
      next_seq_run            = (next_run_state == TSR_RUNNING);
      next_screen_blank       = regs[1][`TSR_MODE_SCROFF_BIT];
      next_fast_cpu_access    = regs[1][`TSR_MODE_SCROFF_BIT];
      // Quarter rate wins when both load-rate bits are set.
      if (regs[1][`TSR_MODE_SHIFT4_BIT]) begin
         next_load_divide = `TSR_LOAD_DIV_QUARTER;
      end else if (regs[1][`TSR_MODE_LOAD2_BIT]) begin
         next_load_divide = `TSR_LOAD_DIV_HALF;
      end else begin
         next_load_divide = `TSR_LOAD_DIV_FULL;
      end
      next_dot_clock_half     = regs[1][`TSR_MODE_DOT2_BIT];
      next_char_clock_8dot    = regs[1][`TSR_MODE_STATE_BIT];
      next_dot_state_ext      = {regs[6][2:1], regs[1][`TSR_MODE_STATE_BIT]};
      next_plane_write_enable = regs[2][3:0];
   end

   tsr_font_map u_font_map (
      .i_choice (font_choice),
      .o_offset (font_offset)
   );

   always_ff @(posedge i_clock) begin
      if (!i_reset_n) begin
         sequencer_index      <= `TSR_RESET_VAL;
         for (int k = 0; k < 8; k++) begin
            regs[k] <= `TSR_RESET_VAL;
         end
         run_state            <= TSR_HALTED;
         o_io_rdata           <= `TSR_RESET_VAL;
         o_io_rd_hit          <= 1'b0;
         o_seq_run            <= 1'b0;
         o_screen_blank       <= 1'b0;
         o_fast_cpu_access    <= 1'b0;
         o_load_divide        <= `TSR_LOAD_DIV_FULL;
         o_dot_clock_half     <= 1'b0;
         o_char_clock_8dot    <= 1'b0;
         o_dot_state_ext      <= 3'h0;
         o_plane_write_enable <= 4'h0;
         o_font_offset        <= 16'h0000;
         o_memory_mode        <= `TSR_RESET_VAL;
         o_aux_mode           <= `TSR_RESET_VAL;
      end else if (i_clock_en) begin
         sequencer_index      <= next_index;
         for (int k = 0; k < 8; k++) begin
            regs[k] <= next_regs[k];
         end
         run_state            <= next_run_state;
         o_io_rdata           <= next_rdata;
         o_io_rd_hit          <= next_rd_hit;
         o_seq_run            <= next_seq_run;
         o_screen_blank       <= next_screen_blank;
         o_fast_cpu_access    <= next_fast_cpu_access;
         o_load_divide        <= next_load_divide;
         o_dot_clock_half     <= next_dot_clock_half;
         o_char_clock_8dot    <= next_char_clock_8dot;
         o_dot_state_ext      <= next_dot_state_ext;
         o_plane_write_enable <= next_plane_write_enable;
         o_font_offset        <= font_offset;
         o_memory_mode        <= regs[4];
         o_aux_mode           <= regs[7];
      end
   end
endmodule // tsr_sequencer_regs
`default_nettype wire

// File: verif/tsr_checker_sva.sv
// Port-level checks on the sequencer register block.
// Assumes a bind from the bench to every tsr_sequencer_regs instance.
`timescale 1ns/1ps
`default_nettype none
module tsr_checker (
   input wire logic        i_clock,
   input wire logic        i_reset_n,
   input wire logic        i_clock_en,
   input wire logic [15:0] i_io_addr,
   input wire logic        i_io_wr,
   input wire logic        i_io_rd,
   input wire logic [7:0]  o_io_rdata,
   input wire logic        o_io_rd_hit,
   input wire logic        o_seq_run,
   input wire logic        o_screen_blank,
   input wire logic        o_fast_cpu_access,
   input wire logic [1:0]  o_load_divide,
   input wire logic [3:0]  o_plane_write_enable
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_reset_n);
   wire logic rd_port = i_clock_en && i_io_rd && (i_io_addr == 16'h03c4 || i_io_addr == 16'h03c5);
   property p_rd_hit; rd_port |=> o_io_rd_hit; endproperty
   // A frozen block keeps its last answer, so a lingering hit is legal only behind a freeze.
   property p_hit_cause;
      (o_io_rd_hit || o_io_rdata != 8'h00) |-> $past(i_io_rd && i_clock_en) || $past(!i_clock_en);
   endproperty
   property p_index_bits; rd_port && i_io_addr == 16'h03c4 |=> o_io_rdata[7:3] == 5'h00; endproperty
   property p_blank_pair; o_screen_blank == o_fast_cpu_access; endproperty
   property p_load_code; o_load_divide != 2'h2; endproperty
   property p_run_cause; $rose(o_seq_run) |-> $past(i_io_wr && i_io_addr == 16'h03c5, 2); endproperty
   // A frozen block must not move the run state or the plane enables.
   property p_frozen;
      !i_clock_en |=> $stable(o_seq_run) && $stable(o_plane_write_enable);
   endproperty
   property p_hit_pulse; o_io_rd_hit && i_clock_en && !rd_port |=> !o_io_rd_hit; endproperty
   a_rd_hit: assert property (p_rd_hit)
      else $error("port read gave no hit");
   a_hit_cause: assert property (p_hit_cause)
      else $error("read data or hit without a read");
   a_index_bits: assert property (p_index_bits)
      else $error("index upper bits not zero");
   a_blank_pair: assert property (p_blank_pair)
      else $error("blank and fast access differ");
   a_load_code: assert property (p_load_code)
      else $error("illegal load divide code");
   a_run_cause: assert property (p_run_cause)
      else $error("sequencer started without a data write");
   a_frozen: assert property (p_frozen)
      else $error("state moved while frozen");
   a_hit_pulse: assert property (p_hit_pulse)
      else $error("read hit stood too long");
   c_run: cover property ($rose(o_seq_run));
   c_blank: cover property (o_screen_blank);
   c_quarter: cover property (o_load_divide == 2'h3);
endmodule // tsr_checker
`default_nettype wire

// File: verif/tsr_sequencer_regs_bench.sv
// Self-checking bench for the sequencer register block.
// Assumes the design package, header and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tsr_sequencer_regs_bench;
   import tsr_pkg::*;
   logic i_clock, i_reset_n, i_clock_en, i_io_wr, i_io_rd, i_attr_font_b, i_ovr;
   logic [15:0] i_io_addr, o_font_offset;
   logic [7:0] i_io_wdata, o_io_rdata, o_memory_mode, o_aux_mode;
   logic [2:0] i_alt_font_choice, o_dot_state_ext;
   logic o_io_rd_hit, o_seq_run, o_screen_blank, o_fast_cpu_access, o_dot_clock_half, o_c8;
   logic [1:0] o_load_divide;
   logic [3:0] o_plane_write_enable;
   int n_fail = 0;
   int checked = 0;
   logic [7:0] mask_tab [8] = '{8'h03, 8'h3d, 8'h0f, 8'h3f, 8'h0e, 8'h00, 8'h06, 8'hfd};
   logic [15:0] offs [8] = '{16'h0000, 16'h4000, 16'h8000, 16'hc000,
                             16'h2000, 16'h6000, 16'ha000, 16'he000};
   logic [7:0] mode_wr [6] = '{8'h3f, 8'h04, 8'h14, 8'h00, 8'h28, 8'h01};
   logic [5:0] mode_ex [6] = '{6'h3f, 6'h04, 6'h0c, 6'h00, 6'h32, 6'h01};
   tsr_sequencer_regs u_tsr_sequencer_regs (.i_clock(i_clock), .i_reset_n(i_reset_n),
      .i_clock_en(i_clock_en), .i_io_addr(i_io_addr), .i_io_wr(i_io_wr), .i_io_rd(i_io_rd),
      .i_io_wdata(i_io_wdata), .i_attr_font_b(i_attr_font_b),
      .i_attribute_controller_font_override(i_ovr), .i_alt_font_choice(i_alt_font_choice),
      .o_io_rdata(o_io_rdata), .o_io_rd_hit(o_io_rd_hit), .o_seq_run(o_seq_run),
      .o_screen_blank(o_screen_blank), .o_fast_cpu_access(o_fast_cpu_access),
      .o_load_divide(o_load_divide), .o_dot_clock_half(o_dot_clock_half),
      .o_char_clock_8dot(o_c8), .o_dot_state_ext(o_dot_state_ext),
      .o_plane_write_enable(o_plane_write_enable), .o_font_offset(o_font_offset),
      .o_memory_mode(o_memory_mode), .o_aux_mode(o_aux_mode));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic test_done;
      $display("checked=%0d n_fail=%0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Strobes drop a full cycle before the next access so no signal is set twice at once.
   task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
      i_io_addr = a;
      i_io_wdata = d;
      i_io_wr = 1'b1;
      @(negedge i_clock) i_io_wr = 1'b0;
      @(negedge i_clock);
   endtask
   task automatic rd(input logic [15:0] a, input logic hit, input logic [7:0] exp);
      i_io_addr = a;
      i_io_rd = 1'b1;
      @(negedge i_clock) i_io_rd = 1'b0;
      chk({o_io_rd_hit, o_io_rdata}, {hit, exp});
      @(negedge i_clock);
   endtask
   task automatic sw(input logic [7:0] idx, input logic [7:0] d);
      io_wr(16'h03c4, idx);
      io_wr(16'h03c5, d);
   endtask
   task automatic settle;
      repeat (2) @(negedge i_clock);
   endtask
   initial begin
      i_clock = 1'b0;
      forever #25 i_clock = ~i_clock;
   end
   initial begin
      #200000;
      n_fail++;
      test_done;
   end
   initial begin
      logic [2:0] c;
      {i_io_wr, i_io_rd, i_attr_font_b, i_ovr, i_reset_n} = '0;
      i_clock_en = 1'b1;
      i_io_addr = 16'h0000;
      i_io_wdata = 8'h00;
      i_alt_font_choice = 3'h0;
      repeat (2) @(posedge i_clock);
      @(negedge i_clock);
      i_reset_n = 1'b1;
      for (int i = 0; i < 8; i++) begin
         io_wr(16'h03c4, i[7:0]);
         rd(16'h03c5, 1'b1, 8'h00);
         io_wr(16'h03c5, 8'hff);
         rd(16'h03c5, 1'b1, mask_tab[i]);
      end
      io_wr(16'h03c4, 8'hff);
      rd(16'h03c4, 1'b1, 8'h07);
      rd(16'h03c6, 1'b0, 8'h00);
      chk({o_memory_mode, o_aux_mode}, 16'h0efd);
      chk(o_dot_state_ext, 3'h7);
      $display("registers test done");
      sw(8'h00, 8'h01);
      chk(o_seq_run, 1'b0);
      for (int i = 0; i < 6; i++) begin
         sw(8'h01, mode_wr[i]);
         chk({o_screen_blank, o_fast_cpu_access}, mode_ex[i][5:4]);
         chk({o_load_divide, o_dot_clock_half, o_c8}, mode_ex[i][3:0]);
      end
      sw(8'h00, 8'h03);
      chk(o_seq_run, 1'b1);
      $display("mode test done");
      for (int i = 0; i < 4; i++) begin
         sw(8'h00, {6'h00, i[0] | i[1], ~i[0]});
         chk(o_seq_run, i == 2);
      end
      $display("run control test done");
      sw(8'h02, 8'h5a);
      chk(o_plane_write_enable, 4'ha);
      i_clock_en = 1'b0;
      io_wr(16'h03c5, 8'h0f);
      i_clock_en = 1'b1;
      chk(o_plane_write_enable, 4'ha);
      rd(16'h03c5, 1'b1, 8'h0a);
      $display("plane mask test done");
      for (int i = 0; i < 8; i++) begin
         c = i[2:0];
         sw(8'h03, {2'b00, ~c[2], c[2], ~c[1], ~c[0], c[1], c[0]});
         i_attr_font_b = 1'b0;
         settle;
         chk(o_font_offset, offs[c]);
         i_attr_font_b = 1'b1;
         settle;
         chk(o_font_offset, offs[~c]);
      end
      i_ovr = 1'b1;
      i_alt_font_choice = 3'h5;
      settle;
      chk(o_font_offset, 16'h6000);
      $display("font test done");
      i_reset_n = 1'b0;
      settle;
      i_reset_n = 1'b1;
      chk({o_seq_run, o_plane_write_enable}, 5'h00);
      chk(o_font_offset, 16'h0000);
      rd(16'h03c4, 1'b1, 8'h00);
      rd(16'h03c5, 1'b1, 8'h00);
      $display("reset test done");
      test_done;
   end
endmodule // tsr_sequencer_regs_bench
bind tsr_sequencer_regs tsr_checker u_tsr_checker (.i_clock(i_clock), .i_reset_n(i_reset_n),
   .i_clock_en(i_clock_en), .i_io_addr(i_io_addr), .i_io_wr(i_io_wr), .i_io_rd(i_io_rd),
   .o_io_rdata(o_io_rdata), .o_io_rd_hit(o_io_rd_hit), .o_seq_run(o_seq_run),
   .o_screen_blank(o_screen_blank), .o_fast_cpu_access(o_fast_cpu_access),
   .o_load_divide(o_load_divide), .o_plane_write_enable(o_plane_write_enable));
`default_nettype wire
